/* logic/isw_pkg.sv */
// shared constants and types of the idle, sleep and wake controller
package isw_pkg;
    localparam int          ISW_DLY_W     = 16;      // width of sleep_delay_time counter
    localparam logic [6:0]  ISW_ADDR_DEF  = 7'h30;   // default 7-bit slave address
    localparam logic [15:0] ISW_DLY_RST   = 16'h0000; // counter value after reset
    localparam int          ISW_SYNC_N    = 3;       // pin synchroniser depth
    localparam logic [3:0]  ISW_ADDR_BITS = 4'h7;    // address bits before r/w bit

    // controller states
    typedef enum logic [2:0] {
        ISW_ST_BOOT,     // one cycle after reset, checks retained context
        ISW_ST_ACTIVE,   // normal operation
        ISW_ST_COUNT,    // sleep_delay_time counting down
        ISW_ST_GOSLEEP,  // waiting for idle tasks, a pending command returns to active
        ISW_ST_SLEEP,    // low power sleep
        ISW_ST_SAVE,     // storing application context
        ISW_ST_OFF,      // context stored, supply may be removed
        ISW_ST_RESTORE   // reloading application context
    } isw_state_t;

    // configuration carried as one bundle
    typedef struct packed {
        logic [ISW_DLY_W-1:0] sleep_delay_time; // delay-to-sleep in clock cycles
        logic                 addr_ovr;         // use addr instead of default
        logic [6:0]           addr;             // reconfigured slave address
    } isw_cfg_t;

    // status outputs carried as one bundle
    typedef struct packed {
        logic sleep;       // in low power sleep
        logic wake;        // one-cycle pulse on wake from sleep
        logic ctx_save;    // request to store context
        logic ctx_restore; // request to reload context
        logic pwr_off_ok;  // supply may now be switched off
        logic app_hold;    // application held until context is back
    } isw_stat_t;
endpackage : isw_pkg

/* logic/isw_addr_match.sv */
// i2c start, address shift and own-address detector
`timescale 1ns/10ps
module isw_addr_match
    import isw_pkg::*;
(
    input  wire logic       mclk_i,   // system clock
    input  wire logic       rst_n_i,  // sync reset, active low
    input  wire logic       ce_i,     // clock enable
    input  wire logic       scl_i,    // bus clock pin level
    input  wire logic       sda_i,    // bus data pin level
    input  wire logic [6:0] addr_i,   // address to match
    output logic            hit_o     // pulse, own address seen
);
    logic [ISW_SYNC_N-1:0] scl_s_r;   // scl synchroniser chain
    logic [ISW_SYNC_N-1:0] sda_s_r;   // sda synchroniser chain
    logic                  scl_f_r;   // filtered scl
    logic                  sda_f_r;   // filtered sda
    logic                  scl_d_r;   // filtered scl, one cycle older
    logic                  sda_d_r;   // filtered sda, one cycle older
    logic                  act_r;     // inside address phase
    logic [3:0]            cnt_r;     // bits shifted so far
    logic [6:0]            sh_r;      // address shift register
    logic                  rise;      // scl rising edge
    logic                  start;     // start condition
    logic                  stop;      // stop condition

    assign rise  = scl_f_r & ~scl_d_r;
    assign start = scl_f_r & scl_d_r & sda_d_r & ~sda_f_r;
    assign stop  = scl_f_r & scl_d_r & ~sda_d_r & sda_f_r;

    // three-stage sync, accept change when stages two and three agree
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            scl_s_r <= '1;
            sda_s_r <= '1;
            scl_f_r <= 1'b1;
            sda_f_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else if (ce_i)
        begin
            scl_s_r <= {scl_s_r[1:0], scl_i};
            sda_s_r <= {sda_s_r[1:0], sda_i};
            if (scl_s_r[1] == scl_s_r[2])
                scl_f_r <= scl_s_r[2];
            if (sda_s_r[1] == sda_s_r[2])
                sda_f_r <= sda_s_r[2];
            scl_d_r <= scl_f_r;
            sda_d_r <= sda_f_r;
        end
    end

    // address phase shifter and compare
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            act_r <= 1'b0;
            cnt_r <= 4'h0;
            sh_r  <= 7'h00;
            hit_o <= 1'b0;
        end
        else if (ce_i)
        begin
            hit_o <= 1'b0;
            if (start)
            begin
                act_r <= 1'b1;   // new frame, address follows
                cnt_r <= 4'h0;
            end
            else if (stop)
                act_r <= 1'b0;   // frame over
            else if (act_r && rise)
            begin
                if (cnt_r == ISW_ADDR_BITS)
                begin
                    act_r <= 1'b0;              // r/w bit, address complete
                    hit_o <= (sh_r == addr_i);
                end
                else
                begin
                    sh_r  <= {sh_r[5:0], sda_f_r};
                    cnt_r <= cnt_r + 4'h1;
                end
            end
        end
    end

    // a hit only follows a complete address equal to the match value
    addr_hit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        hit_o |-> $past(sh_r) == $past(addr_i) && $past(cnt_r) == ISW_ADDR_BITS)
        else $error("address hit without matching address");
endmodule : isw_addr_match

/* logic/isw_ctrl.sv */
// idle, sleep, wake and hibernation controller top
`timescale 1ns/10ps
module isw_ctrl
    import isw_pkg::*;
(
    input  wire logic              mclk_i,              // 40 mhz system clock
    input  wire logic              rst_n_i,             // sync reset, active low
    input  wire logic              ce_i,                // clock enable, freezes all
    input  wire isw_pkg::isw_cfg_t cfg_i,               // delay and address setup
    input  wire logic              busy_i,              // command being processed
    input  wire logic              cmd_pend_i,          // command waiting
    input  wire logic              idle_task_busy_i,    // background task running
    input  wire logic              hib_req_i,           // request to hibernate
    input  wire logic              ctx_valid_i,         // retained context present
    input  wire logic              ctx_save_done_i,     // context store finished
    input  wire logic              ctx_restore_done_i,  // context reload finished
    input  wire logic              scl_i,               // bus clock pin
    input  wire logic              sda_i,               // bus data pin
    output isw_pkg::isw_stat_t     stat_o,              // power state outputs
    output logic                   addr_hit_o           // pulse, own address seen
);
    import isw_pkg::*;

    isw_state_t           state_r;   // current state
    isw_state_t           state_nxt; // next state
    logic [ISW_DLY_W-1:0] cnt_r;     // sleep_delay_time counter
    logic [ISW_DLY_W-1:0] cnt_nxt;   // next counter value
    logic [6:0]           own_addr;  // effective slave address
    logic                 hit;       // own address seen this cycle
    logic                 idle_now;  // nothing to do this cycle
    logic                 abort;     // activity during sleep entry

    // default address unless software reconfigured it
    assign own_addr = cfg_i.addr_ovr ? cfg_i.addr : ISW_ADDR_DEF;
    assign idle_now = ~busy_i & ~cmd_pend_i & ~hit;
    assign abort    = hit | busy_i | cmd_pend_i;

    // bus address detector
    isw_addr_match u_match (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .addr_i  (own_addr),
        .hit_o   (hit)
    );

    // next state and counter
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            ISW_ST_BOOT:
            begin
                // context present means we came back from hibernation
                state_nxt = ctx_valid_i ? ISW_ST_RESTORE : ISW_ST_ACTIVE;
            end
            ISW_ST_ACTIVE:
            begin
                if (hib_req_i)
                    state_nxt = ISW_ST_SAVE;
                else if (idle_now)
                begin
                    state_nxt = ISW_ST_COUNT;
                    cnt_nxt   = cfg_i.sleep_delay_time;
                end
            end
            ISW_ST_COUNT:
            begin
                if (abort)
                    state_nxt = ISW_ST_ACTIVE;
                else if (hib_req_i)
                    state_nxt = ISW_ST_SAVE;
                else if (cnt_r == '0)
                    state_nxt = ISW_ST_GOSLEEP;
                else
                    cnt_nxt = cnt_r - {{(ISW_DLY_W-1){1'b0}}, 1'b1};
            end
            ISW_ST_GOSLEEP:
            begin
                if (abort)
                    state_nxt = ISW_ST_ACTIVE;
                else if (hib_req_i)
                    state_nxt = ISW_ST_SAVE;
                else if (!idle_task_busy_i)
                    state_nxt = ISW_ST_SLEEP;
            end
            ISW_ST_SLEEP:
            begin
                if (hit)
                    state_nxt = ISW_ST_ACTIVE;
                else if (hib_req_i)
                    state_nxt = ISW_ST_SAVE;
            end
            ISW_ST_SAVE:
            begin
                if (ctx_save_done_i)
                    state_nxt = ISW_ST_OFF;
            end
            ISW_ST_OFF:
            begin
                state_nxt = ISW_ST_OFF;  // left only by power-up reset
            end
            ISW_ST_RESTORE:
            begin
                if (ctx_restore_done_i)
                    state_nxt = ISW_ST_ACTIVE;
            end
            default:
            begin
                state_nxt = ISW_ST_BOOT;
            end
        endcase
    end

    // state and counter registers
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= ISW_ST_BOOT;
            cnt_r   <= ISW_DLY_RST;
        end
        else if (ce_i)
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // registered outputs, status decoded from next state, address pulse copied from hit
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            stat_o     <= '0;
            addr_hit_o <= 1'b0;
        end
        else if (ce_i)
        begin
            stat_o.sleep       <= (state_nxt == ISW_ST_SLEEP);
            stat_o.wake        <= (state_r == ISW_ST_SLEEP) && (state_nxt == ISW_ST_ACTIVE);
            stat_o.ctx_save    <= (state_nxt == ISW_ST_SAVE);
            stat_o.ctx_restore <= (state_nxt == ISW_ST_RESTORE);
            stat_o.pwr_off_ok  <= (state_nxt == ISW_ST_OFF);
            // application waits until context is fully back
            stat_o.app_hold    <= (state_nxt == ISW_ST_RESTORE) ||
                                  (state_nxt == ISW_ST_BOOT);
            addr_hit_o         <= hit;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // sleep is entered only with nothing pending and tasks done
    sleep_entry_a: assert property ($rose(stat_o.sleep) |->
        $past(!cmd_pend_i && !idle_task_busy_i && state_r == ISW_ST_GOSLEEP))
        else $error("sleep entered with work outstanding");

    // own address in sleep wakes on the next edge
    wake_hit_a: assert property (ce_i && state_r == ISW_ST_SLEEP && hit |=>
        !stat_o.sleep && stat_o.wake && state_r == ISW_ST_ACTIVE)
        else $error("no wake after address match");

    // going idle loads the configured delay
    delay_load_a: assert property (ce_i && state_r == ISW_ST_ACTIVE && idle_now
        && !hib_req_i |=> state_r == ISW_ST_COUNT && cnt_r == $past(cfg_i.sleep_delay_time))
        else $error("delay counter not loaded on idle");

    // counter steps down by one while undisturbed
    delay_step_a: assert property (ce_i && state_r == ISW_ST_COUNT && !abort
        && !hib_req_i && cnt_r != '0 |=> cnt_r == $past(cnt_r) - 16'h0001)
        else $error("delay counter did not decrement");

    // expiry leads to the go-to-sleep wait, not straight to sleep
    expiry_go_a: assert property (ce_i && state_r == ISW_ST_COUNT && !abort
        && !hib_req_i && cnt_r == '0 |=> state_r == ISW_ST_GOSLEEP && !stat_o.sleep)
        else $error("expiry did not start go-to-sleep");

    // busy background task keeps the procedure waiting
    task_stall_a: assert property (ce_i && state_r == ISW_ST_GOSLEEP
        && idle_task_busy_i && !abort && !hib_req_i |=> state_r == ISW_ST_GOSLEEP)
        else $error("go-to-sleep did not wait for tasks");

    // activity during sleep entry returns to active
    entry_abort_a: assert property (ce_i && (state_r == ISW_ST_COUNT
        || state_r == ISW_ST_GOSLEEP) && abort |=> state_r == ISW_ST_ACTIVE)
        else $error("activity did not abort sleep entry");

    // supply release only after a finished context store
    save_first_a: assert property ($rose(stat_o.pwr_off_ok) |->
        $past(stat_o.ctx_save) && $past(ctx_save_done_i))
        else $error("power off allowed before context stored");

    // application held throughout a context reload
    restore_hold_a: assert property (ce_i && state_r == ISW_ST_RESTORE
        && !ctx_restore_done_i |=> stat_o.ctx_restore && stat_o.app_hold && !stat_o.sleep)
        else $error("application released during restore");

    // with zero delay, idle reaches the go-to-sleep wait two edges later
    auto_sleep_a: assert property (ce_i && state_r == ISW_ST_ACTIVE && idle_now
        && !hib_req_i && cfg_i.sleep_delay_time == 16'h0000 ##1 ce_i && !abort
        && !hib_req_i |=> state_r == ISW_ST_GOSLEEP)
        else $error("zero delay did not reach go-to-sleep");
endmodule : isw_ctrl

/* dv/isw_host_model.sv */
// behavioural i2c bus master that addresses the controller
`timescale 1ns/10ps
module isw_host_model #(
    parameter int HALF_CYC  = 6,    // mclk cycles per scl phase
    parameter int GUARD_CYC = 2000  // 50 us at 40 mhz
)(
    input  wire logic mclk_i,  // system clock
    input  wire logic hit_i,   // own address seen, stands in for ack
    output logic      scl_o,   // bus clock, idles high by pull-up
    output logic      sda_o    // bus data, idles high by pull-up
);
    logic seen;  // hit noticed in current frame

    // released lines sit at the pull-up level
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        seen  = 1'b0;
    end

    // wait n cycles, noting any hit pulse
    task automatic hold(input int n);
        repeat (n)
        begin
            @(negedge mclk_i);
            if (hit_i === 1'b1) seen = 1'b1;
        end
    endtask : hold

    // one scl pulse carrying bit b, data set while scl low
    task automatic clk_bit(input logic b);
        sda_o = b;
        hold(HALF_CYC);
        scl_o = 1'b1;
        hold(HALF_CYC);
        scl_o = 1'b0;
    endtask : clk_bit

    // guard gap, start, address msb first, r/w, ack slot, stop
    task automatic frame(input logic [6:0] a, input logic rw);
        hold(GUARD_CYC); // gap since previous stop
        seen  = 1'b0;
        sda_o = 1'b0;
        hold(HALF_CYC);
        scl_o = 1'b0;
        for (int i = 6; i >= 0; i--) clk_bit(a[i]);
        clk_bit(rw);
        clk_bit(1'b1); // ack slot, sda released
        sda_o = 1'b0;
        hold(HALF_CYC);
        scl_o = 1'b1;
        hold(HALF_CYC);
        sda_o = 1'b1;
    endtask : frame

    // repeat unanswered frames until a hit or tries run out
    task automatic access(input logic [6:0] a, input logic rw, input int tries,
                          output logic ok);
        ok = 1'b0;
        for (int t = 0; t < tries && ok !== 1'b1; t++)
        begin
            frame(a, rw); // retry on no answer
            ok = seen;
        end
    endtask : access
endmodule : isw_host_model

/* dv/test_isw_ctrl.sv */
// self-checking bench of the idle, sleep and wake controller
`timescale 1ns/10ps
module test_isw_ctrl;
    import isw_pkg::*;
    logic       mclk;                  // bench clock
    logic       rst_n;                 // sync reset, active low
    logic       ce;                    // clock enable
    isw_cfg_t   cfg;                   // delay and address setup
    logic       busy, cmd_pend, itb;   // activity inputs
    logic       hib_req, ctx_valid;    // hibernation inputs
    logic       save_done, rest_done;  // context handshakes
    logic       scl, sda;              // bus pins from host model
    isw_stat_t  stat_o;                // power state outputs
    logic       addr_hit_o;            // own address pulse
    logic [5:0] hit_cnt  = 6'h00;      // cycles with address pulse
    logic [5:0] wake_cnt = 6'h00;      // cycles with wake pulse
    logic [5:0] h0, w0;                // counter snapshots
    logic [6:0] ovr;                   // random override address
    logic       ok;                    // host got an answer
    int         d;                     // sleep delay in use
    int         n_fail   = 0;          // mismatches
    int         n_checks = 0;          // comparisons

    isw_ctrl dut (.mclk_i(mclk), .rst_n_i(rst_n), .ce_i(ce), .cfg_i(cfg), .busy_i(busy),
        .cmd_pend_i(cmd_pend), .idle_task_busy_i(itb), .hib_req_i(hib_req),
        .ctx_valid_i(ctx_valid), .ctx_save_done_i(save_done),
        .ctx_restore_done_i(rest_done), .scl_i(scl), .sda_i(sda), .stat_o(stat_o),
        .addr_hit_o(addr_hit_o));
    isw_host_model host (.mclk_i(mclk), .hit_i(addr_hit_o), .scl_o(scl), .sda_o(sda));

    // 25 ns clock
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // pulse counters
    always @(posedge mclk)
    begin
        if (addr_hit_o === 1'b1) hit_cnt <= hit_cnt + 6'h01;
        if (stat_o.wake === 1'b1) wake_cnt <= wake_cnt + 6'h01;
    end

    // expected status word
    function automatic isw_stat_t st(input logic sl, sv, rs, po, ah);
        st = '{sleep: sl, wake: 1'b0, ctx_save: sv, ctx_restore: rs,
               pwr_off_ok: po, app_hold: ah};
    endfunction : st

    // edges from first idle edge until sleep shows
    function automatic int sleep_lat(input int dly);
        return dly + 3;
    endfunction : sleep_lat

    task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    task automatic report_and_stop;
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    // four cycle reset, busy held so the device stays active
    task automatic do_reset(input logic cv);
        rst_n = 1'b0;
        busy  = 1'b1;
        {cmd_pend, itb, hib_req, save_done, rest_done} = 5'h00;
        tick(4);
        chk(stat_o, 6'h00);
        chk({5'h00, addr_hit_o}, 6'h00);
        rst_n     = 1'b1;
        ctx_valid = cv;
        tick(1);
        ctx_valid = 1'b0;
    endtask : do_reset

    // go idle and expect sleep exactly after the delay
    task automatic go_sleep(input int dly);
        busy = 1'b0;
        tick(sleep_lat(dly) - 1);
        chk(stat_o, 6'h00); // in go-to-sleep wait, not yet asleep
        tick(1);
        chk(stat_o, st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0)); // asleep
    endtask : go_sleep

    // watchdog
    initial
    begin
        repeat (60000) @(posedge mclk);
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        {rst_n, ce, busy, cmd_pend, itb, hib_req} = 6'h10;
        {ctx_valid, save_done, rest_done} = 3'h0;
        cfg = '0;
        void'($urandom(32'h3c42));
        for (int i = 0; i < 3; i++)
        begin
            // first pass is the zero delay corner, the rest are random
            d = (i == 0) ? 0 : int'($urandom_range(1, 6));
            cfg.sleep_delay_time = 16'(d);
            do_reset(1'b0);
            go_sleep(d); // zero delay first, then random delays
        end
        d = 4;
        cfg.sleep_delay_time = 16'(d);
        do_reset(1'b0);
        ce   = 1'b0;
        busy = 1'b0;
        tick(d + 10);
        chk(stat_o, 6'h00); // frozen by clock enable
        ce = 1'b1;
        go_sleep(d);
        do_reset(1'b0);
        busy = 1'b0;
        tick(d);
        busy = 1'b1;
        tick(d + 3);
        chk(stat_o, 6'h00); // activity in count
        go_sleep(d); // full delay again
        do_reset(1'b0);
        itb  = 1'b1;
        busy = 1'b0;
        tick(d + 8);
        chk(stat_o, 6'h00); // stalled by idle task
        cmd_pend = 1'b1;
        tick(1);
        cmd_pend = 1'b0;
        itb      = 1'b0;
        go_sleep(d); // pending command reloads delay
        cfg.sleep_delay_time = 16'h0400;
        h0 = hit_cnt;
        w0 = wake_cnt;
        host.access(ISW_ADDR_DEF ^ 7'h01, 1'b0, 2, ok);
        chk({5'h00, ok}, 6'h00); // foreign address
        chk(stat_o, st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0)); // still asleep
        host.access(ISW_ADDR_DEF, 1'b1, 2, ok);
        chk(6'(hit_cnt - h0), 6'h01); // default address
        chk(6'(wake_cnt - w0), 6'h01); // one wake pulse
        chk(stat_o, 6'h00); // awake
        ovr = 7'($urandom_range(0, 127));
        if (ovr == ISW_ADDR_DEF) ovr = ovr ^ 7'h01;
        busy = 1'b1;
        tick(2);
        cfg = '{sleep_delay_time: 16'(d), addr_ovr: 1'b1, addr: ovr};
        go_sleep(d);
        cfg.sleep_delay_time = 16'h0400;
        h0 = hit_cnt;
        host.access(ISW_ADDR_DEF, 1'b0, 1, ok);
        chk({5'h00, ok}, 6'h00); // default ignored once overridden
        host.access(ovr, 1'b0, 1, ok);
        chk(6'(hit_cnt - h0), 6'h01); // override address
        chk(stat_o, 6'h00); // awake
        cfg = '0;
        cfg.sleep_delay_time = 16'(d);
        do_reset(1'b0);
        hib_req = 1'b1;
        tick(1);
        hib_req = 1'b0;
        chk(stat_o, st(1'b0, 1'b1, 1'b0, 1'b0, 1'b0)); // save request
        tick(5);
        chk(stat_o, st(1'b0, 1'b1, 1'b0, 1'b0, 1'b0)); // held until done
        save_done = 1'b1;
        tick(1);
        save_done = 1'b0;
        chk(stat_o, st(1'b0, 1'b0, 1'b0, 1'b1, 1'b0)); // supply may drop
        do_reset(1'b1);
        chk(stat_o, st(1'b0, 1'b0, 1'b1, 1'b0, 1'b1)); // reload, app held
        tick(5);
        chk(stat_o, st(1'b0, 1'b0, 1'b1, 1'b0, 1'b1)); // held until done
        rest_done = 1'b1;
        tick(1);
        rest_done = 1'b0;
        chk(stat_o, 6'h00); // resumes
        go_sleep(d); // normal operation after restore
        report_and_stop();
    end
endmodule : test_isw_ctrl
